// ==== src/cmpc_consts.svh ====
`ifndef CMPC_CONSTS_SVH
`define CMPC_CONSTS_SVH
// ****************************************
// timing
// ****************************************
`define CMPC_CLK_MHZ    100
`define CMPC_NS_PER_US  1000
`define CMPC_SETTLE_NS  1000
// ****************************************
// strap slots, each a two-bit level code
// ****************************************
`define CMPC_LW         2
`define CMPC_NPIN       15
`define CMPC_NMON       3
`define CMPC_P_OUT2     0
`define CMPC_P_OUT5     1
`define CMPC_P_FOS      2
`define CMPC_P_SELM     3
`define CMPC_P_FMT0     4
`define CMPC_P_FMT1     5
`define CMPC_P_BW0      6
`define CMPC_P_DIV0     8
`define CMPC_P_MUL0     10
`define CMPC_P_TBL      14
`define CMPC_N_BW       2
`define CMPC_N_DIV      2
`define CMPC_N_MUL      4
// ****************************************
// register map
// ****************************************
`define CMPC_AW         8
`define CMPC_A_CTRL     8'h00
`define CMPC_A_STAT     8'h04
`define CMPC_A_LVL      8'h08
`define CMPC_CTRL_W     2
`define CMPC_CTRL_RST   2'h0
`define CMPC_B_MANSEL   0
`define CMPC_B_FREEZE   1
`endif

// ==== src/cmpc_pkg.sv ====
package cmpc_pkg;
  typedef enum logic [1:0] {LVL_LO, LVL_MID, LVL_HI} cmpc_lvl_t;
  typedef enum logic [2:0] {
    FMT_RSVD, FMT_LVDS, FMT_CML, FMT_LVPECL, FMT_LVDS_LOW, FMT_CMOS,
    FMT_OFF
  } cmpc_fmt_t;
  typedef enum logic [1:0] {FOS_OFF, FOS_STRATUM3, FOS_SONET} cmpc_fos_t;
  typedef enum logic [1:0] {SEL_MANUAL, SEL_NONREV, SEL_REV} cmpc_selm_t;
  typedef enum logic [1:0] {ACT_NONE, ACT_IN1, ACT_IN2} cmpc_act_t;

  // cmp[1] above upper threshold, cmp[0] below lower threshold;
  // floating rests between both, contradictory reads as mid too
  function automatic cmpc_lvl_t cmpc_decode(input logic [1:0] cmp);
    unique case (cmp)
      2'h2:    return LVL_HI;
      2'h1:    return LVL_LO;
      default: return LVL_MID;
    endcase
  endfunction

  function automatic cmpc_fmt_t cmpc_fmt(input cmpc_lvl_t s1,
                                         input cmpc_lvl_t s0);
    unique case ({s1, s0})
      {LVL_HI, LVL_MID}:  return FMT_LVDS;
      {LVL_HI, LVL_LO}:   return FMT_CML;
      {LVL_MID, LVL_HI}:  return FMT_LVPECL;
      {LVL_MID, LVL_LO}:  return FMT_LVDS_LOW;
      {LVL_LO, LVL_HI}:   return FMT_CMOS;
      {LVL_LO, LVL_MID}:  return FMT_OFF;
      default:            return FMT_RSVD;
    endcase
  endfunction
endpackage

// ==== src/cmpc_pin_ctl.sv ====
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "cmpc_consts.svh"
// Notes on behaviour
// - output-2 control low enables path 2, mid disables it, high bypasses.
// - bypass is never granted while the shared format is cmos.
// - an undriven three-level strap resolves to mid.
// - output-5 control low keeps path 5 on with the shared format.
// - output-5 control mid forces cmos on path 5 only.
// - output-5 control high powers path 5 down with its pins released.
// - offset control low keeps the input-2 offset check out of selection.
// - offset control mid picks the stratum 3/3E, high the sonet threshold.
// - each active indicator is high only while its input feeds the pll.
// - two straps set the output 3/4 ratio against output 2.
// - four straps plus the table choice set the multiplier.
// - two straps set the loop bandwidth.
// - cmos drives both pins alike, other formats drive a true pair.
// - method low is manual, mid auto non-revertive, high auto revertive.
module cmpc_pin_ctl
  import cmpc_pkg::*;
#(
  parameter int SETTLE_NS  = `CMPC_SETTLE_NS,
  parameter int SETTLE_CYC = (SETTLE_NS * `CMPC_CLK_MHZ
                             + `CMPC_NS_PER_US - 1) / `CMPC_NS_PER_US
) (
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  // apb slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [`CMPC_AW-1:0]   paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // three-level straps, {above upper, below lower}
  input  wire logic [1:0]            out2_disable_bypass_ctl_i,
  input  wire logic [1:0]            out5_path_ctl_i,
  input  wire logic [1:0]            freq_offset_ctl_i,
  input  wire logic [1:0]            clock_select_method_i,
  input  wire logic [1:0]            signal_format_sel_0_i,
  input  wire logic [1:0]            signal_format_sel_1_i,
  input  wire logic [1:0]            loop_bw_sel_0_i,
  input  wire logic [1:0]            loop_bw_sel_1_i,
  input  wire logic [1:0]            out34_ratio_sel_0_i,
  input  wire logic [1:0]            out34_ratio_sel_1_i,
  input  wire logic [1:0]            mult_sel_0_i,
  input  wire logic [1:0]            mult_sel_1_i,
  input  wire logic [1:0]            mult_sel_2_i,
  input  wire logic [1:0]            mult_sel_3_i,
  input  wire logic [1:0]            freq_table_choice_i,
  // input monitors
  input  wire logic                  ref_in_1_valid_i,
  input  wire logic                  ref_in_2_valid_i,
  input  wire logic                  freq_offset_check_i,
  // pll output levels
  input  wire logic                  pll_clk_2_i,
  input  wire logic                  pll_clk_5_i,
  // path control
  output logic                       out2_path_en_o,
  output logic                       pll_bypass_o,
  output cmpc_fmt_t                  out_fmt_o,
  output cmpc_fmt_t                  out5_fmt_o,
  output logic                       out5_pwr_en_o,
  output cmpc_fos_t                  fos_thresh_o,
  output cmpc_selm_t                 sel_method_o,
  output logic [2*`CMPC_N_DIV-1:0]   out34_ratio_sel_o,
  output logic [2*`CMPC_N_BW-1:0]    loop_bw_sel_o,
  output logic [2*`CMPC_N_MUL-1:0]   mult_sel_o,
  output logic [1:0]                 freq_table_choice_o,
  // active input indicators
  output logic                       in1_active_ind_o,
  output logic                       in2_active_ind_o,
  // clock output pins
  output logic                       clk_out_2_p_o,
  output logic                       clk_out_2_n_o,
  output logic                       clk_out_5_p_o,
  output logic                       clk_out_5_n_o,
  output logic                       clk_out_5_oe_n_o
);
  localparam int RW = `CMPC_LW * `CMPC_NPIN;
  localparam int CW = $clog2(SETTLE_CYC + 1);
  localparam logic [CW-1:0] CNT_END = CW'(SETTLE_CYC - 1);

  // ****************************************
  // strap synchroniser and settle filter
  // ****************************************
  logic [RW-1:0]             strap_raw;
  logic [RW-1:0]             sync1, sync2, dec, cand, cfg;
  logic [RW-1:0]             next_sync1, next_sync2, next_cand, next_cfg;
  logic [CW-1:0]             cnt, next_cnt;
  logic [`CMPC_CTRL_W-1:0]   ctrl;

  assign strap_raw = {freq_table_choice_i, mult_sel_3_i, mult_sel_2_i,
                      mult_sel_1_i, mult_sel_0_i, out34_ratio_sel_1_i,
                      out34_ratio_sel_0_i, loop_bw_sel_1_i,
                      loop_bw_sel_0_i, signal_format_sel_1_i,
                      signal_format_sel_0_i, clock_select_method_i,
                      freq_offset_ctl_i, out5_path_ctl_i,
                      out2_disable_bypass_ctl_i};

  for (genvar g = 0; g < `CMPC_NPIN; g++) begin : g_dec
    assign dec[g*`CMPC_LW +: `CMPC_LW] =
      cmpc_decode(sync2[g*`CMPC_LW +: `CMPC_LW]);
  end

  function automatic cmpc_lvl_t lv(input int p);
    return cmpc_lvl_t'(cfg[p*`CMPC_LW +: `CMPC_LW]);
  endfunction

  // a strap must hold one level for the whole window, so a slow edge
  // crossing mid on its way never reaches a path
  always_comb begin
    next_sync1 = strap_raw;
    next_sync2 = sync1;
    next_cand  = dec;
    next_cnt   = '0;
    next_cfg   = cfg;
    if (dec == cand) begin
      next_cnt = cnt;
      if (cnt == CNT_END) begin
        if (!ctrl[`CMPC_B_FREEZE]) begin
          next_cfg = cand;
        end
      end else begin
        next_cnt = cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sync1 <= '0;
      sync2 <= '0;
      cand  <= {`CMPC_NPIN{LVL_MID}};
      cfg   <= {`CMPC_NPIN{LVL_MID}};
      cnt   <= '0;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      cand  <= next_cand;
      cfg   <= next_cfg;
      cnt   <= next_cnt;
    end
  end

  // ****************************************
  // monitor synchroniser
  // ****************************************
  logic [`CMPC_NMON-1:0] mon1, mon2, next_mon1, next_mon2;

  always_comb begin
    next_mon1 = {freq_offset_check_i, ref_in_2_valid_i, ref_in_1_valid_i};
    next_mon2 = mon1;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mon1 <= '0;
      mon2 <= '0;
    end else begin
      mon1 <= next_mon1;
      mon2 <= next_mon2;
    end
  end

  // ****************************************
  // decoded configuration
  // ****************************************
  cmpc_lvl_t  out2_lvl, out5_lvl;
  cmpc_fmt_t  fmt;
  cmpc_fos_t  freq_offset_check;
  cmpc_selm_t selm;
  logic       in1_ok, in2_ok, bypass_refused;

  always_comb begin
    out2_lvl = lv(`CMPC_P_OUT2);
    out5_lvl = lv(`CMPC_P_OUT5);
    fmt      = cmpc_fmt(lv(`CMPC_P_FMT1), lv(`CMPC_P_FMT0));
    unique case (lv(`CMPC_P_FOS))
      LVL_LO:  freq_offset_check = FOS_OFF;
      LVL_HI:  freq_offset_check = FOS_SONET;
      default: freq_offset_check = FOS_STRATUM3;
    endcase
    unique case (lv(`CMPC_P_SELM))
      LVL_LO:  selm = SEL_MANUAL;
      LVL_HI:  selm = SEL_REV;
      default: selm = SEL_NONREV;
    endcase
    in1_ok = mon2[0];
    // offset alarm only disqualifies input 2 when checking is on
    in2_ok = mon2[1] && !(freq_offset_check != FOS_OFF && mon2[2]);
    bypass_refused = (out2_lvl == LVL_HI) && (fmt == FMT_CMOS);
  end

  // ****************************************
  // input selection
  // ****************************************
  cmpc_act_t act, next_act;

  always_comb begin
    next_act = act;
    unique case (selm)
      SEL_MANUAL: begin
        next_act = ctrl[`CMPC_B_MANSEL] ? ACT_IN2 : ACT_IN1;
      end
      SEL_REV: begin
        if (in1_ok) begin
          next_act = ACT_IN1;
        end else if (in2_ok) begin
          next_act = ACT_IN2;
        end
      end
      SEL_NONREV: begin
        // keeps a good input even once a preferred one recovers
        if (act == ACT_IN1 && !in1_ok && in2_ok) begin
          next_act = ACT_IN2;
        end else if (act == ACT_IN2 && !in2_ok && in1_ok) begin
          next_act = ACT_IN1;
        end else if (act == ACT_NONE) begin
          if (in1_ok) begin
            next_act = ACT_IN1;
          end else if (in2_ok) begin
            next_act = ACT_IN2;
          end
        end
      end
      default: next_act = act;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      act <= ACT_NONE;
    end else begin
      act <= next_act;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  logic next_p2, next_n2, next_p5, next_n5;

  always_comb begin
    next_p2 = (out2_lvl != LVL_MID) && pll_clk_2_i;
    next_n2 = (out2_lvl != LVL_MID) &&
              ((fmt == FMT_CMOS) ? pll_clk_2_i : !pll_clk_2_i);
    next_p5 = (out5_lvl != LVL_HI) && pll_clk_5_i;
    next_n5 = (out5_lvl != LVL_HI) &&
              ((out5_lvl == LVL_MID || fmt == FMT_CMOS) ?
               pll_clk_5_i : !pll_clk_5_i);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      out2_path_en_o      <= 1'b0;
      pll_bypass_o        <= 1'b0;
      out_fmt_o           <= FMT_RSVD;
      out5_fmt_o          <= FMT_CMOS;
      out5_pwr_en_o       <= 1'b0;
      clk_out_5_oe_n_o    <= 1'b1;
      fos_thresh_o        <= FOS_STRATUM3;
      sel_method_o        <= SEL_NONREV;
      out34_ratio_sel_o   <= '0;
      loop_bw_sel_o       <= '0;
      mult_sel_o          <= '0;
      freq_table_choice_o <= '0;
      in1_active_ind_o    <= 1'b0;
      in2_active_ind_o    <= 1'b0;
      clk_out_2_p_o       <= 1'b0;
      clk_out_2_n_o       <= 1'b0;
      clk_out_5_p_o       <= 1'b0;
      clk_out_5_n_o       <= 1'b0;
    end else begin
      out2_path_en_o      <= out2_lvl != LVL_MID;
      pll_bypass_o        <= out2_lvl == LVL_HI && !bypass_refused;
      out_fmt_o           <= fmt;
      out5_fmt_o          <= out5_lvl == LVL_MID ? FMT_CMOS : fmt;
      out5_pwr_en_o       <= out5_lvl != LVL_HI;
      clk_out_5_oe_n_o    <= out5_lvl == LVL_HI;
      fos_thresh_o        <= freq_offset_check;
      sel_method_o        <= selm;
      out34_ratio_sel_o   <= cfg[`CMPC_P_DIV0*`CMPC_LW +:
                                 `CMPC_N_DIV*`CMPC_LW];
      loop_bw_sel_o       <= cfg[`CMPC_P_BW0*`CMPC_LW +:
                                 `CMPC_N_BW*`CMPC_LW];
      mult_sel_o          <= cfg[`CMPC_P_MUL0*`CMPC_LW +:
                                 `CMPC_N_MUL*`CMPC_LW];
      freq_table_choice_o <= cfg[`CMPC_P_TBL*`CMPC_LW+:`CMPC_LW];
      in1_active_ind_o    <= next_act == ACT_IN1;
      in2_active_ind_o    <= next_act == ACT_IN2;
      clk_out_2_p_o       <= next_p2;
      clk_out_2_n_o       <= next_n2;
      clk_out_5_p_o       <= next_p5;
      clk_out_5_n_o       <= next_n5;
    end
  end

  // ****************************************
  // apb slave, zero wait states
  // ****************************************
  logic [`CMPC_CTRL_W-1:0] next_ctrl;
  logic [31:0]             next_rdata, stat_word;
  logic                    hit, setup, wr_acc;

  always_comb begin
    hit = paddr_i == `CMPC_A_CTRL || paddr_i == `CMPC_A_STAT ||
          paddr_i == `CMPC_A_LVL;
    setup  = psel_i && !penable_i;
    wr_acc = psel_i && penable_i && pwrite_i;
    stat_word = 32'h0;
    stat_word[16:0] = {act, selm, freq_offset_check, out5_fmt_o, out_fmt_o,
                       out5_lvl, out2_lvl, bypass_refused};
    next_ctrl = ctrl;
    if (wr_acc && paddr_i == `CMPC_A_CTRL) begin
      next_ctrl = pwdata_i[`CMPC_CTRL_W-1:0];
    end
    next_rdata = prdata_o;
    if (setup) begin
      next_rdata = 32'h0;
      if (!pwrite_i) begin
        unique case (paddr_i)
          `CMPC_A_CTRL: next_rdata[`CMPC_CTRL_W-1:0] = ctrl;
          `CMPC_A_STAT: next_rdata = stat_word;
          `CMPC_A_LVL:  next_rdata[RW-1:0] = cfg;
          default:      next_rdata = 32'h0;
        endcase
      end
    end
  end

  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !hit;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl     <= `CMPC_CTRL_RST;
      prdata_o <= 32'h0;
    end else begin
      ctrl     <= next_ctrl;
      prdata_o <= next_rdata;
    end
  end
endmodule // cmpc_pin_ctl

// ==== testbench/cmpc_pin_ctl_assertions.sv ====
`timescale 1ns/1ps
// ********************
// pin path checks
// ********************
module cmpc_pin_ctl_chk
  import cmpc_pkg::*;
(
  // clock and reset
  input wire logic      core_clk_i,
  input wire logic      rst_n_i,
  // watched ports
  input wire logic      pll_clk_2_i,
  input wire logic      out2_path_en_o,
  input wire logic      pll_bypass_o,
  input wire cmpc_fmt_t out_fmt_o,
  input wire cmpc_fmt_t out5_fmt_o,
  input wire logic      out5_pwr_en_o,
  input wire logic      in1_active_ind_o,
  input wire logic      in2_active_ind_o,
  input wire logic      clk_out_2_p_o,
  input wire logic      clk_out_2_n_o,
  input wire logic      clk_out_5_p_o,
  input wire logic      clk_out_5_n_o,
  input wire logic      clk_out_5_oe_n_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // two cycles of steady path state, pins lag their source by one edge
  sequence s_path2_on;
    out2_path_en_o && $past(out2_path_en_o) && $stable(out_fmt_o);
  endsequence
  a_bypass_not_cmos: assert property (
    pll_bypass_o |-> out_fmt_o != FMT_CMOS)
    else $error("bypass granted with cmos format");
  a_bypass_keeps_path: assert property (
    pll_bypass_o |-> out2_path_en_o)
    else $error("bypass without output 2 enabled");
  a_path2_off_quiet: assert property (!out2_path_en_o [*2] |->
    !clk_out_2_p_o && !clk_out_2_n_o)
    else $error("output 2 pins move while disabled");
  a_out2_pin_copy: assert property (s_path2_on |->
    clk_out_2_p_o == $past(pll_clk_2_i))
    else $error("output 2 does not follow pll clock");
  a_cmos_same_pins: assert property (
    s_path2_on and out_fmt_o == FMT_CMOS
    |-> clk_out_2_n_o == clk_out_2_p_o)
    else $error("cmos pins differ");
  a_diff_pair_pins: assert property (
    s_path2_on and out_fmt_o != FMT_CMOS
    |-> clk_out_2_n_o != clk_out_2_p_o)
    else $error("differential pins not complementary");
  a_out5_off_hiz: assert property (!out5_pwr_en_o [*2] |->
    clk_out_5_oe_n_o && !clk_out_5_p_o && !clk_out_5_n_o)
    else $error("output 5 driven while powered down");
  a_out5_on_drives: assert property (
    out5_pwr_en_o [*2] |-> !clk_out_5_oe_n_o)
    else $error("output 5 released while active");
  a_out5_fmt_src: assert property (
    out5_pwr_en_o && out5_fmt_o != out_fmt_o
    |-> out5_fmt_o == FMT_CMOS)
    else $error("output 5 format from wrong source");
  a_ind_exclusive: assert property (
    !(in1_active_ind_o && in2_active_ind_o))
    else $error("both inputs shown active");
  c_bypass: cover property (pll_bypass_o);
  c_in2_active: cover property (in2_active_ind_o);
  c_out5_cmos: cover property (out5_fmt_o == FMT_CMOS &&
    out_fmt_o == FMT_LVDS);
endmodule // cmpc_pin_ctl_chk

bind cmpc_pin_ctl cmpc_pin_ctl_chk u_chk (.core_clk_i, .rst_n_i, .pll_clk_2_i,
  .out2_path_en_o, .pll_bypass_o, .out_fmt_o, .out5_fmt_o, .out5_pwr_en_o,
  .in1_active_ind_o, .in2_active_ind_o, .clk_out_2_p_o, .clk_out_2_n_o,
  .clk_out_5_p_o, .clk_out_5_n_o, .clk_out_5_oe_n_o);

// ==== testbench/cmpc_strap_model.sv ====
`timescale 1ns/1ps
// ********************
// board straps
// ********************
module cmpc_strap_model (
  // per slot: 0 low, 1 mid, 2 high, 3 undriven
  input  wire logic [29:0] lvl_i,
  // per slot comparators, {above upper, below lower}
  output logic      [29:0] cmp_o
);
  always_comb begin
    for (int s = 0; s < 15; s++) begin
      case (lvl_i[2*s +: 2])
        2'h0:    cmp_o[2*s +: 2] = 2'h1;
        2'h2:    cmp_o[2*s +: 2] = 2'h2;
        // weak pull pair parks a loose pin between thresholds
        default: cmp_o[2*s +: 2] = 2'h0;
      endcase
    end
  end
endmodule // cmpc_strap_model

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
// ********************
// bench
// ********************
module testbench;
  import cmpc_pkg::*;
  logic        core_clk_i = 1'b0, rst_n_i = 1'b0, er;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic        pready_o, pslverr_o, pll_clk_2_i = 1'b0, pll_clk_5_i = 1'b0;
  logic        ref_in_1_valid_i = 1'b0, ref_in_2_valid_i = 1'b0;
  logic        freq_offset_check_i = 1'b0;
  logic        out2_path_en_o, pll_bypass_o, out5_pwr_en_o;
  cmpc_fmt_t   out_fmt_o, out5_fmt_o;
  cmpc_fos_t   fos_thresh_o;
  cmpc_selm_t  sel_method_o;
  logic [3:0]  out34_ratio_sel_o, loop_bw_sel_o;
  logic [7:0]  mult_sel_o;
  logic [1:0]  freq_table_choice_o;
  logic        in1_active_ind_o, in2_active_ind_o;
  logic        clk_out_2_p_o, clk_out_2_n_o;
  logic        clk_out_5_p_o, clk_out_5_n_o, clk_out_5_oe_n_o;
  logic [29:0] lvl = {15{2'h3}}, cur, cmp;
  int          fails = 0, tests_run = 0, cyc = 0;

  cmpc_pin_ctl #(.SETTLE_CYC(4)) uut (.*,
    .out2_disable_bypass_ctl_i(cmp[1:0]), .out5_path_ctl_i(cmp[3:2]),
    .freq_offset_ctl_i(cmp[5:4]), .clock_select_method_i(cmp[7:6]),
    .signal_format_sel_0_i(cmp[9:8]), .signal_format_sel_1_i(cmp[11:10]),
    .loop_bw_sel_0_i(cmp[13:12]), .loop_bw_sel_1_i(cmp[15:14]),
    .out34_ratio_sel_0_i(cmp[17:16]), .out34_ratio_sel_1_i(cmp[19:18]),
    .mult_sel_0_i(cmp[21:20]), .mult_sel_1_i(cmp[23:22]),
    .mult_sel_2_i(cmp[25:24]), .mult_sel_3_i(cmp[27:26]),
    .freq_table_choice_i(cmp[29:28]));
  cmpc_strap_model u_straps (.lvl_i(lvl), .cmp_o(cmp));

  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    pll_clk_2_i <= 1'($urandom);
    pll_clk_5_i <= 1'($urandom);
    if (cyc == 20000) begin
      fails = fails + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // long wait covers sync plus settle plus commit
  task automatic apply();
    @(posedge core_clk_i);
    lvl <= cur;
    repeat (20) @(posedge core_clk_i);
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    // pready_o is tied high, so this wait ends after one edge
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic act(input logic [1:0] e);
    // two sync edges, one register edge, then one edge to settle
    repeat (4) @(posedge core_clk_i);
    chk({in1_active_ind_o, in2_active_ind_o}, e);
  endtask
  function automatic logic [1:0] ec(input logic [1:0] c);
    return (c == 2'h3) ? 2'h1 : c;
  endfunction

  initial begin
    void'($urandom(32'h056E));
    cur = lvl;
    repeat (4) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (20) @(posedge core_clk_i);
    chk(out2_path_en_o, 1'b0);
    chk(fos_thresh_o, FOS_STRATUM3);
    chk(sel_method_o, SEL_NONREV);
    chk({mult_sel_o, loop_bw_sel_o}, 12'h555);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h15555555);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h00002D0A);
    apb(1'b0, 8'h0C, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("test float done");
    for (int f = 1; f >= 0; f--) begin
      for (int v = 0; v < 3; v++) begin
        cur[9:8] = f ? 2'h2 : 2'h1;
        cur[11:10] = f ? 2'h0 : 2'h2;
        cur[1:0] = 2'(v);
        apply();
        chk(out_fmt_o, f ? FMT_CMOS : FMT_LVDS);
        chk(out2_path_en_o, v != 1);
        chk(pll_bypass_o, v == 2 && f == 0);
      end
    end
    $display("test out2 done");
    cur[1:0] = 2'h0;
    for (int v = 0; v < 3; v++) begin
      cur[3:2] = 2'(v);
      apply();
      chk(out5_pwr_en_o, v != 2);
      chk(clk_out_5_oe_n_o, v == 2);
      if (v < 2) chk(out5_fmt_o, v ? FMT_CMOS : FMT_LVDS);
      chk(out_fmt_o, FMT_LVDS);
    end
    $display("test out5 done");
    ref_in_2_valid_i <= 1'b1;
    freq_offset_check_i <= 1'b1;
    cur[5:4] = 2'h0;
    apply();
    chk(fos_thresh_o, FOS_OFF);
    act(2'b01);
    ref_in_1_valid_i <= 1'b1;
    act(2'b01);
    cur[5:4] = 2'h1;
    apply();
    chk(fos_thresh_o, FOS_STRATUM3);
    act(2'b10);
    cur[5:4] = 2'h2;
    apply();
    chk(fos_thresh_o, FOS_SONET);
    cur[7:6] = 2'h2;
    ref_in_1_valid_i <= 1'b0;
    freq_offset_check_i <= 1'b0;
    apply();
    chk(sel_method_o, SEL_REV);
    act(2'b01);
    ref_in_1_valid_i <= 1'b1;
    act(2'b10);
    cur[7:6] = 2'h0;
    apply();
    chk(sel_method_o, SEL_MANUAL);
    apb(1'b1, 8'h00, 32'h1);
    act(2'b01);
    apb(1'b1, 8'h00, 32'h0);
    act(2'b10);
    $display("test select done");
    // two-cycle blip on a bandwidth strap must be ignored
    @(posedge core_clk_i);
    lvl[13:12] <= 2'h2;
    repeat (2) @(posedge core_clk_i);
    lvl[13:12] <= cur[13:12];
    repeat (20) @(posedge core_clk_i);
    chk(loop_bw_sel_o, 4'h5);
    // freeze holds the old straps until it is lifted
    apb(1'b1, 8'h00, 32'h2);
    cur[13:12] = 2'h2;
    apply();
    chk(loop_bw_sel_o, 4'h5);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, 8'h00, 32'h0);
    repeat (20) @(posedge core_clk_i);
    chk(loop_bw_sel_o, 4'h6);
    repeat (8) begin
      for (int s = 6; s < 15; s++) cur[2*s +: 2] = 2'($urandom_range(3));
      apply();
      chk(loop_bw_sel_o, {ec(cur[15:14]), ec(cur[13:12])});
      chk(out34_ratio_sel_o, {ec(cur[19:18]), ec(cur[17:16])});
      chk(mult_sel_o, {ec(cur[27:26]), ec(cur[25:24]),
                       ec(cur[23:22]), ec(cur[21:20])});
      chk(freq_table_choice_o, ec(cur[29:28]));
    end
    $display("test selects done");
    complete_run();
  end
endmodule // testbench
